// >>> hw/ufis_defines.svh
// Constants of the UART queue and interrupt status block.
// Assumes inclusion by bare name from design and bench files.
`ifndef UFIS_DEFINES_SVH
`define UFIS_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define UFIS_IDX_QDATA 6'h03
`define UFIS_IDX_INTR 6'h25
`define UFIS_IDX_MODE 6'h30
`define UFIS_IDX_CMD 6'h31
`define UFIS_IDX_CHSTAT 6'h32
`define UFIS_IDX_LEVEL 6'h33

// Mode register fields.
`define UFIS_MODE_RXTRIG_LSB 0
`define UFIS_MODE_TXTRIG_LSB 2
`define UFIS_MODE_BLOCKERR_BIT 4
`define UFIS_MODE_RESET 8'h00
`define UFIS_MASK_RESET 8'h00

// Interrupt status bit positions.
`define UFIS_ISR_COS 7
`define UFIS_ISR_WDOG 6
`define UFIS_ISR_ADDR 5
`define UFIS_ISR_FLOW 4
`define UFIS_ISR_CT 3
`define UFIS_ISR_BRK 2
`define UFIS_ISR_RX 1
`define UFIS_ISR_TX 0

// Receive entry fields.
`define UFIS_ENT_BREAK 10
`define UFIS_ENT_FRAME 9
`define UFIS_ENT_PARITY 8

// Command codes.
`define UFIS_CMD_RST_ERR 8'h04
`define UFIS_CMD_RST_BRK 8'h05
`define UFIS_CMD_STOP_CT 8'h09
`define UFIS_CMD_RST_COS 8'h0C
`define UFIS_CMD_RST_FLOW 8'h0E
`define UFIS_CMD_RST_ADDR 8'h1B

// Receive trigger levels and transmit trigger levels for a 256 deep queue.
`define UFIS_RX_HALF 9'h080
`define UFIS_RX_3Q 9'h0C0
`define UFIS_TX_LVL1 9'h040
`define UFIS_TX_LVL2 9'h080
`define UFIS_TX_LVL3 9'h0C0

// Receiver watchdog threshold in bit times.
`define UFIS_WDOG_BITS 7'd64

// Bus responses.
`define UFIS_RESP_OKAY 2'h0
`define UFIS_RESP_SLVERR 2'h2

`endif

// >>> hw/ufis_pkg.sv
// Types shared by the UART queue and interrupt status block.
// Assumes ufis_defines.svh is on the include path.
package ufis_pkg;

   typedef logic [1:0] ufis_resp_t;

   typedef enum logic [1:0] {
      RXT_READY,
      RXT_HALF,
      RXT_3Q,
      RXT_FULL
   } ufis_rxtrig_t;

   typedef enum logic [1:0] {
      TXT_EMPTY,
      TXT_LVL1,
      TXT_LVL2,
      TXT_LVL3
   } ufis_txtrig_t;

endpackage : ufis_pkg

// >>> hw/ufis_top.sv
// Receive and transmit queues, interrupt status and mask for one UART channel.
// Assumes an AXI4-Lite master, a receive shifter and a transmit shifter on clk.
//
// Overview of operation
// - Ready mode: flag set on entry, cleared empty.
// - Full mode: flag only while all 256 used.
// - Held character sets flag on entering queue.
// - Half/three-quarter modes: flag at or above level.
// - Empty receive queue keeps flag at zero.
// - Default transmit trigger: flag only when empty.
// - Transmit flag while fill below trigger level.
// - Full transmit queue keeps flag at zero.
// - Status and mask both one drive request.
// - Mask bits seven to zero select sources.
// - Watchdog mask gates 64 idle bit times.
// - Counter zero raises masked source.
// - Receive queue 11 bits by 256 entries.
// - Head status bits shown, updated per read.
// - Entry holds break, framing, parity, data.
// - Block mode accumulates errors until reset command.
// - Transmit queue 8 bits by 256 bytes.
// - Data offset read pops head receive entry.
// - Watchdog sets past 64 bits, read clears.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "ufis_defines.svh"

module ufis_top #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output ufis_pkg::ufis_resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output ufis_pkg::ufis_resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic rxCharValid,
   input wire logic [7:0] rxCharData,
   input wire logic rxCharBreak,
   input wire logic rxCharFrameErr,
   input wire logic rxCharParityErr,
   output logic rxCharReady,
   output logic txCharValid,
   output logic [7:0] txCharData,
   input wire logic txCharTake,
   input wire logic bitTick,
   input wire logic changeOfState,
   input wire logic addrRecogEvent,
   input wire logic flowCharEvent,
   input wire logic counterZero,
   input wire logic breakChange,
   output logic interruptRequestN
);
   import ufis_pkg::*;

   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;
   localparam logic [CW-1:0] FULLCNT = CW'(DEPTH);

   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // A hardware set wins over a clear in the same cycle.
   function automatic logic sticky(input logic q, input logic set, input logic clr);
      sticky = set | (q & ~clr);
   endfunction : sticky

   function automatic logic [CW-1:0] nextCount(input logic [CW-1:0] c, input logic inc, input logic dec);
      nextCount = c + CW'(inc) - CW'(dec);
   endfunction : nextCount

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx == `UFIS_IDX_QDATA) || (idx == `UFIS_IDX_INTR) || (idx == `UFIS_IDX_MODE) ||
               (idx == `UFIS_IDX_CMD) || (idx == `UFIS_IDX_CHSTAT) || (idx == `UFIS_IDX_LEVEL);
   endfunction : mapped

   // ****************************************************************
   // State
   // ****************************************************************
   logic [10:0] rxMem [DEPTH];
   logic [7:0] txMem [DEPTH];
   logic [PW-1:0] rxWr_q, rxRd_q, txWr_q, txRd_q;
   logic [CW-1:0] rxCount_q, txCount_q, rxCount_d, txCount_d;
   logic [7:0] mask_q, mode_q;
   logic cos_q, wdog_q, addr_q, flow_q, ct_q, brk_q, rxFlag_q, txFlag_q;
   logic [2:0] errAcc_q, chStat_q;
   logic [6:0] wdCnt_q;
   logic awHeld_q, wHeld_q;
   logic [AW-1:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   ufis_resp_t bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic rxReady_q, txValid_q, interrupt_request_n_q;
   logic [7:0] txData_q;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire awFire = awvalid && awready_q;
   wire wFire = wvalid && wready_q;
   wire awHave = awHeld_q || awFire;
   wire wHave = wHeld_q || wFire;
   wire [AW-1:0] wrAddr = awHeld_q ? awAddr_q : awaddr;
   wire [31:0] wrData = wHeld_q ? wData_q : wdata;
   wire [3:0] wrStrb = wHeld_q ? wStrb_q : wstrb;
   wire wrDo = awHave && wHave && !bvalid_q;
   wire [5:0] wrIdx = wrAddr[7:2];
   wire wrLane0 = wrDo && wrStrb[0];
   wire wrHit = mapped(wrIdx) && (wrAddr[1:0] == 2'h0);
   wire [7:0] wrByte = wrData[7:0];
   wire txPushReq = wrLane0 && wrHit && (wrIdx == `UFIS_IDX_QDATA);
   wire txFull = (txCount_q == FULLCNT);
   wire txPush = txPushReq && !txFull;
   wire maskWr = wrLane0 && wrHit && (wrIdx == `UFIS_IDX_INTR);
   wire modeWr = wrLane0 && wrHit && (wrIdx == `UFIS_IDX_MODE);
   wire cmdWr = wrLane0 && wrHit && (wrIdx == `UFIS_IDX_CMD);
   wire wrErr = !wrHit || (txPushReq && txFull);

   wire arFire = arvalid && arready_q;
   wire [5:0] rdIdx = araddr[7:2];
   wire rdHit = mapped(rdIdx) && (araddr[1:0] == 2'h0);
   wire rxEmpty = (rxCount_q == '0);
   wire qRead = arFire && rdHit && (rdIdx == `UFIS_IDX_QDATA);
   wire rxPop = qRead && !rxEmpty;

   // ****************************************************************
   // Commands
   // ****************************************************************
   wire cmdRstErr = cmdWr && (wrByte == `UFIS_CMD_RST_ERR);
   wire cmdRstBrk = cmdWr && (wrByte == `UFIS_CMD_RST_BRK);
   wire cmdStopCt = cmdWr && (wrByte == `UFIS_CMD_STOP_CT);
   wire cmdRstCos = cmdWr && (wrByte == `UFIS_CMD_RST_COS);
   wire cmdRstFlow = cmdWr && (wrByte == `UFIS_CMD_RST_FLOW);
   wire cmdRstAddr = cmdWr && (wrByte == `UFIS_CMD_RST_ADDR);

   // ****************************************************************
   // Receive queue
   // ****************************************************************
   // A character offered while the queue is full stays in the shifter and
   // enters on a later cycle, so the level-based flag rises again then.
   wire rxFull = (rxCount_q == FULLCNT);
   wire rxPush = rxCharValid && !rxFull;
   wire [10:0] rxEntry = {rxCharBreak, rxCharFrameErr, rxCharParityErr, rxCharData};
   wire [10:0] rxHead = rxMem[rxRd_q];
   wire blockMode = mode_q[`UFIS_MODE_BLOCKERR_BIT];
   wire [2:0] errAcc_d = (rxPush ? rxEntry[10:8] : 3'h0) | (cmdRstErr ? 3'h0 : errAcc_q);
   assign rxCount_d = nextCount(rxCount_q, rxPush, rxPop);

   // ****************************************************************
   // Service flags
   // ****************************************************************
   wire [1:0] rxTrigField = mode_q[`UFIS_MODE_RXTRIG_LSB +: 2];
   wire [1:0] txTrigField = mode_q[`UFIS_MODE_TXTRIG_LSB +: 2];
   ufis_rxtrig_t rxTrig;
   ufis_txtrig_t txTrig;
   assign rxTrig = ufis_rxtrig_t'(rxTrigField);
   assign txTrig = ufis_txtrig_t'(txTrigField);
   logic rxFlag_d, txFlag_d;

   always_comb begin
      case (rxTrig)
         RXT_READY: rxFlag_d = (rxCount_d != '0);
         RXT_HALF: rxFlag_d = (rxCount_d >= `UFIS_RX_HALF);
         RXT_3Q: rxFlag_d = (rxCount_d >= `UFIS_RX_3Q);
         RXT_FULL: rxFlag_d = (rxCount_d == FULLCNT);
         default: rxFlag_d = 1'b0;
      endcase
   end

   always_comb begin
      case (txTrig)
         TXT_EMPTY: txFlag_d = (txCount_d == '0);
         TXT_LVL1: txFlag_d = (txCount_d < `UFIS_TX_LVL1);
         TXT_LVL2: txFlag_d = (txCount_d < `UFIS_TX_LVL2);
         TXT_LVL3: txFlag_d = (txCount_d < `UFIS_TX_LVL3);
         default: txFlag_d = 1'b0;
      endcase
   end

   // ****************************************************************
   // Transmit queue and output stage
   // ****************************************************************
   // The output stage holds the byte the shifter is sending; the queue count
   // excludes it, which costs one extra byte of storage beyond the queue.
   wire stageFree = !txValid_q || txCharTake;
   wire txPop = stageFree && (txCount_q != '0);
   assign txCount_d = nextCount(txCount_q, txPush, txPop);

   // ****************************************************************
   // Watchdog and status
   // ****************************************************************
   wire rxEvent = rxPush || qRead;
   // One pulse on the tick that passes the limit, so a queue read can still clear the bit.
   wire wdSet = bitTick && !rxEvent && (wdCnt_q == `UFIS_WDOG_BITS);
   wire [7:0] interrupt_status = {cos_q, wdog_q, addr_q, flow_q, ct_q, brk_q, rxFlag_q, txFlag_q};
   wire irqAny = |(interrupt_status & mask_q);
   wire rxNewHead = rxPush && (rxCount_q == CW'(rxPop));
   wire [2:0] headStat = rxNewHead ? rxEntry[10:8] : rxMem[rxPop ? rxRd_q + 1'b1 : rxRd_q][10:8];
   wire [2:0] chStat_d = blockMode ? errAcc_d : (rxCount_d == '0 ? 3'h0 : headStat);

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [31:0] rdMux;

   always_comb begin
      rdMux = 32'h0000_0000;
      case (rdIdx)
         `UFIS_IDX_QDATA: rdMux = rxEmpty ? 32'h0000_0000 : {21'h0, rxHead};
         `UFIS_IDX_INTR: rdMux = {24'h0, interrupt_status};
         `UFIS_IDX_MODE: rdMux = {24'h0, mode_q};
         `UFIS_IDX_CHSTAT: rdMux = {29'h0, chStat_q};
         `UFIS_IDX_LEVEL: rdMux = {7'h0, txCount_q, 7'h0, rxCount_q};
         default: rdMux = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rxPush) begin
         rxMem[rxWr_q] <= rxEntry;
      end
      if (txPush) begin
         txMem[txWr_q] <= wrByte;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxWr_q <= '0;
         rxRd_q <= '0;
         txWr_q <= '0;
         txRd_q <= '0;
         rxCount_q <= '0;
         txCount_q <= '0;
      end else begin
         rxWr_q <= rxWr_q + PW'(rxPush);
         rxRd_q <= rxRd_q + PW'(rxPop);
         txWr_q <= txWr_q + PW'(txPush);
         txRd_q <= txRd_q + PW'(txPop);
         rxCount_q <= rxCount_d;
         txCount_q <= txCount_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         txValid_q <= 1'b0;
         txData_q <= 8'h00;
         rxReady_q <= 1'b0;
      end else begin
         if (txPop) begin
            txData_q <= txMem[txRd_q];
         end
         if (stageFree) begin
            txValid_q <= txPop;
         end
         rxReady_q <= (rxCount_d != FULLCNT);
      end
   end

   // ****************************************************************
   // Status, mask, mode
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_q <= `UFIS_MASK_RESET;
         mode_q <= `UFIS_MODE_RESET;
         rxFlag_q <= 1'b0;
         txFlag_q <= 1'b0;
         errAcc_q <= 3'h0;
         chStat_q <= 3'h0;
         interrupt_request_n_q <= 1'b1;
      end else begin
         if (maskWr) begin
            mask_q <= wrByte;
         end
         if (modeWr) begin
            mode_q <= wrByte;
         end
         rxFlag_q <= rxFlag_d;
         txFlag_q <= txFlag_d;
         errAcc_q <= errAcc_d;
         chStat_q <= chStat_d;
         interrupt_request_n_q <= !irqAny;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cos_q <= 1'b0;
         wdog_q <= 1'b0;
         addr_q <= 1'b0;
         flow_q <= 1'b0;
         ct_q <= 1'b0;
         brk_q <= 1'b0;
         wdCnt_q <= 7'd0;
      end else begin
         cos_q <= sticky(cos_q, changeOfState, cmdRstCos);
         wdog_q <= sticky(wdog_q, wdSet, qRead);
         addr_q <= sticky(addr_q, addrRecogEvent, cmdRstAddr);
         flow_q <= sticky(flow_q, flowCharEvent, cmdRstFlow);
         ct_q <= sticky(ct_q, counterZero, cmdStopCt);
         brk_q <= sticky(brk_q, breakChange, cmdRstBrk);
         if (rxEvent) begin
            wdCnt_q <= 7'd0;
         end else if (bitTick && (wdCnt_q <= `UFIS_WDOG_BITS)) begin
            wdCnt_q <= wdCnt_q + 7'd1;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `UFIS_RESP_OKAY;
      end else begin
         if (awFire) begin
            awAddr_q <= awaddr;
         end
         if (wFire) begin
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (wrDo) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wrErr ? `UFIS_RESP_SLVERR : `UFIS_RESP_OKAY;
         end else begin
            if (awFire) begin
               awHeld_q <= 1'b1;
               awready_q <= 1'b0;
            end
            if (wFire) begin
               wHeld_q <= 1'b1;
               wready_q <= 1'b0;
            end
            if (bvalid_q && bready) begin
               bvalid_q <= 1'b0;
               awready_q <= 1'b1;
               wready_q <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `UFIS_RESP_OKAY;
      end else if (arFire) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rdHit ? rdMux : 32'h0000_0000;
         rresp_q <= rdHit ? `UFIS_RESP_OKAY : `UFIS_RESP_SLVERR;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign rxCharReady = rxReady_q;
   assign txCharValid = txValid_q;
   assign txCharData = txData_q;
   assign interruptRequestN = interrupt_request_n_q;

endmodule : ufis_top

// >>> sim/ufis_top_monitor.sv
// Concurrent checks on the bus, queue and request ports of the queue block.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
module ufis_top_monitor
   import ufis_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [AW-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire ufis_pkg::ufis_resp_t bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [AW-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire ufis_pkg::ufis_resp_t rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic rxCharReady,
   input wire logic txCharValid,
   input wire logic [7:0] txCharData,
   input wire logic txCharTake,
   input wire logic interruptRequestN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of the mask, so the request can be judged without seeing inside.
   logic [7:0] maskQ;
   always_ff @(posedge clk) begin
      if (rst) maskQ <= 8'h00;
      else if (awvalid && awready && wvalid && wready && awaddr == 8'h94 && wstrb[0]) maskQ <= wdata[7:0];
   end
   property p_post_rst; $fell(rst) |=> rxCharReady && interruptRequestN && !txCharValid; endproperty
   a_post_rst: assert property (p_post_rst) else $error("bad outputs after reset");
   property p_req_off; (maskQ == 8'h00)[*3] |-> interruptRequestN; endproperty
   a_req_off: assert property (p_req_off) else $error("request with all sources masked");
   property p_b_ans; awvalid && awready && wvalid && wready |=> bvalid; endproperty
   a_b_ans: assert property (p_b_ans) else $error("write response late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_ans; arvalid && arready |=> rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read response late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data changed while waiting");
   property p_tx_hold; txCharValid && !txCharTake |=> txCharValid && $stable(txCharData); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("staged byte changed before take");
   property p_unmapped; arvalid && arready && araddr == 8'hFC |=> rresp == 2'h2 && rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule : ufis_top_monitor
bind ufis_top ufis_top_monitor #(.DEPTH(DEPTH), .AW(AW)) i_ufis_top_monitor (.clk, .rst, .awaddr, .awvalid,
   .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
   .rresp, .rvalid, .rready, .rxCharReady, .txCharValid, .txCharData, .txCharTake, .interruptRequestN);

// >>> sim/ufis_char_model.sv
// Stand-in for the receive and transmit shifters beside the queue block.
// Assumes the bench fills rxQ and reads txSeen by hierarchical reference.
`timescale 1ns/100ps
module ufis_char_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic txStall,
   input wire logic rxCharReady,
   input wire logic txCharValid,
   input wire logic [7:0] txCharData,
   output logic rxCharValid,
   output logic [10:0] rxEntry,
   output logic txCharTake
);
   logic [10:0] rxQ[$];
   logic [7:0] txSeen[$];
   initial begin
      rxCharValid = 1'h0;
      rxEntry = 11'h000;
      txCharTake = 1'h0;
   end
   // An idle entry bus toggles so a stale character can never pass for a fresh one.
   always @(posedge clk) begin
      if (rst) begin
         rxCharValid <= 1'h0;
         txCharTake <= 1'h0;
      end else begin
         if (rxCharValid && rxCharReady) void'(rxQ.pop_front());
         rxCharValid <= rxQ.size() > 0;
         rxEntry <= (rxQ.size() > 0) ? rxQ[0] : ~rxEntry;
         if (txCharTake && txCharValid) txSeen.push_back(txCharData);
         txCharTake <= txCharValid && !txStall && !txCharTake;
      end
   end
endmodule : ufis_char_model

// >>> sim/ufis_top_tb.sv
// Self-checking bench for the queue and interrupt status block.
// Assumes the design, the character model and the monitor are compiled first.
`timescale 1ns/100ps
`include "ufis_defines.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin nErrors++; $display("BAD %s exp=%h got=%h", nm, e, g); end end
module ufis_top_tb;
   import ufis_pkg::*;
   localparam logic [7:0] A_DATA = {`UFIS_IDX_QDATA, 2'h0};
   localparam logic [7:0] A_INTR = {`UFIS_IDX_INTR, 2'h0};
   localparam logic [7:0] A_MODE = {`UFIS_IDX_MODE, 2'h0};
   localparam logic [7:0] A_CMD = {`UFIS_IDX_CMD, 2'h0};
   localparam logic [7:0] A_CHST = {`UFIS_IDX_CHSTAT, 2'h0};
   logic clk = 1'h0, rst = 1'h1, bitTick = 1'h0, txStall = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev = 8'h00, txCharData;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, rxCharReady, txCharValid, txCharTake, rxCharValid;
   logic interruptRequestN;
   ufis_resp_t bresp, rresp, resp;
   logic [10:0] rxEntry, ent;
   logic [10:0] expRx[$];
   logic [7:0] expTx[$];
   int nErrors = 0, comparisons = 0, cycles = 0, seed = 32'h4B36;
   int evBit[6] = '{7, 6, 5, 4, 3, 2};
   logic [7:0] evCmd[6] = '{8'h0C, 8'h00, 8'h1B, 8'h0E, 8'h09, 8'h05};
   ufis_top #(.DEPTH(256), .AW(8)) i_ufis_top (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .rxCharValid, .rxCharData(rxEntry[7:0]), .rxCharBreak(rxEntry[10]), .rxCharFrameErr(rxEntry[9]),
      .rxCharParityErr(rxEntry[8]), .rxCharReady, .txCharValid, .txCharData, .txCharTake, .bitTick,
      .changeOfState(ev[7]), .addrRecogEvent(ev[5]), .flowCharEvent(ev[4]), .counterZero(ev[3]),
      .breakChange(ev[2]), .interruptRequestN);
   ufis_char_model i_ufis_char_model (.clk, .rst, .txStall, .rxCharReady, .txCharValid, .txCharData,
      .rxCharValid, .rxEntry, .txCharTake);
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         nErrors++;
         end_sim();
      end
   end
   // Bus tasks hold each channel until its own ready is sampled high.
   // Answer ready rises only after the answer is seen, so the slave must hold it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid === 1'h1 && bready !== 1'h1) bready <= 1'h1;
      end while (!(bvalid === 1'h1 && bready === 1'h1));
      resp = bresp;
      bready <= 1'h0;
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid === 1'h1 && rready !== 1'h1) rready <= 1'h1;
      end while (!(rvalid === 1'h1 && rready === 1'h1));
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask : rdr
   task automatic st(input logic [7:0] e);
      rdr(A_INTR);
      `CHK("status", e, rd[7:0])
   endtask : st
   task automatic pops(input int n);
      repeat (n) begin
         ent = expRx.pop_front();
         rdr(A_DATA);
         `CHK("rx entry", {21'h0, ent}, rd)
      end
   endtask : pops
   task automatic rxs(input logic [10:0] e);
      i_ufis_char_model.rxQ.push_back(e);
      expRx.push_back(e);
   endtask : rxs
   task automatic rxw(input int h);
      while (i_ufis_char_model.rxQ.size() > h) @(posedge clk);
      repeat (4) @(posedge clk);
   endtask : rxw
   task automatic txp(input logic [7:0] b, input ufis_resp_t e);
      wr(A_DATA, {24'h0, b});
      `CHK("push resp", e, resp)
      if (e === 2'h0) expTx.push_back(b);
   endtask : txp
   task automatic tdone(input string nm);
      $display("test %s done, mismatches so far %0d", nm, nErrors);
   endtask : tdone
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      int i;
      int b;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      st(8'h01);
      rdr(8'hFC);
      `CHK("unmapped rd", 2'h2, resp)
      wr(8'hF8, 32'h0);
      `CHK("unmapped wr", 2'h2, resp)
      tdone("reset");
      for (i = 0; i < 6; i++) rxs(11'($random(seed)));
      rxw(0);
      st(8'h03);
      while (expRx.size() > 0) begin
         rdr(A_CHST);
         `CHK("head status", {29'h0, expRx[0][10:8]}, rd)
         pops(1);
      end
      st(8'h01);
      tdone("character");
      wr(A_MODE, 32'h10);
      wr(A_CMD, 32'h04);
      rxs(11'h1A5);
      rxs(11'h45A);
      rxs(11'h033);
      rxw(0);
      pops(3);
      rdr(A_CHST);
      `CHK("block err", 32'h5, rd)
      wr(A_CMD, 32'h04);
      rdr(A_CHST);
      `CHK("block clr", 32'h0, rd)
      tdone("block");
      wr(A_MODE, 32'h3);
      for (i = 0; i < 257; i++) begin
         rxs(11'(i[7:0]));
         if (i == 254) begin
            rxw(0);
            st(8'h01);
         end
      end
      rxw(1);
      st(8'h03);
      `CHK("held", 1, i_ufis_char_model.rxQ.size())
      pops(1);
      rxw(0);
      st(8'h03);
      pops(64);
      wr(A_MODE, 32'h2);
      st(8'h03);
      pops(1);
      st(8'h01);
      wr(A_MODE, 32'h1);
      st(8'h03);
      pops(63);
      st(8'h03);
      pops(1);
      st(8'h01);
      pops(127);
      st(8'h01);
      tdone("levels");
      txStall <= 1'h1;
      wr(A_MODE, 32'h4);
      for (i = 0; i < 64; i++) txp(8'($random(seed)), 2'h0);
      st(8'h01);
      txp(8'($random(seed)), 2'h0);
      st(8'h00);
      wr(A_MODE, 32'h0);
      st(8'h00);
      for (i = 0; i < 192; i++) txp(8'($random(seed)), 2'h0);
      txp(8'h5A, 2'h2);
      st(8'h00);
      txStall <= 1'h0;
      while (i_ufis_char_model.txSeen.size() < 257) @(posedge clk);
      foreach (expTx[k]) `CHK("tx byte", expTx[k], i_ufis_char_model.txSeen[k])
      st(8'h01);
      tdone("transmit");
      for (i = 0; i < 6; i++) begin
         b = evBit[i];
         repeat ((b == 6) ? 65 : 1) begin
            @(posedge clk);
            if (b == 6) bitTick <= 1'h1;
            else ev[b] <= 1'h1;
            @(posedge clk);
            bitTick <= 1'h0;
            ev <= 8'h00;
         end
         st(8'h01 | (8'h01 << b));
         wr(A_INTR, {24'h0, 8'h01 << b});
         repeat (3) @(posedge clk);
         `CHK("irq on", 1'h0, interruptRequestN)
         wr(A_INTR, {24'h0, ~(8'h01 << b) & 8'hFE});
         repeat (3) @(posedge clk);
         `CHK("irq off", 1'h1, interruptRequestN)
         wr(A_INTR, 32'h0);
         if (b == 6) rdr(A_DATA);
         else wr(A_CMD, {24'h0, evCmd[i]});
         st(8'h01);
      end
      tdone("events");
      end_sim();
   end
endmodule : ufis_top_tb
